// >>> core/link_port_defines.svh
// Offsets, field positions, reset values and timing counts of the link port.
// Assumes inclusion by bare name from files under core/.
//
// Operation
// - Separate eight-bit input and output data buses face the line unit.
// - Line read address is four bits: top bit low, low three select register.
// - Line write address is four bits: top bit enables, low three select.
// - Read and write addresses can be presented independently in one cycle.
// - A control interface gives the line unit clock sync and data strobe.
// - Eight byte addresses decoded; bytes individually accessible, pairs form four words; code decodes host_addr[2:1] only, host_be picks the byte.
// - Bytes zero and two hold handshakes; bytes four to seven are the data port.
// - Host sets request-in with function code; device answers setting ready-in.
// - Host loads data, clears request-in; device takes data, clears ready-in.
// - Device loads data port first, then sets ready-out with function code.
`ifndef LINK_PORT_DEFINES_SVH
`define LINK_PORT_DEFINES_SVH

// ============================================================
// Register byte offsets
`define OFF_IN_HS 3'h0
`define OFF_OUT_HS 3'h2
`define OFF_DATA_LO 3'h4
`define OFF_DATA_HI 3'h6

// ============================================================
// Field positions
`define FUNC_LSB 0
`define FUNC_MSB 3
`define REQ_IN_BIT 5
`define RDY_IN_BIT 7
`define RDY_OUT_BIT 7
`define LU_ADDR_TOP 3

// ============================================================
// Reset values
`define RST_BYTE 8'h00
`define RST_FUNC 4'h0
`define RST_DATA 32'h0000_0000

// ============================================================
// Timing counts
`define LU_RD_WAIT 2'h3
`define CLK_SYNC_DIV 4'hF

`endif

// >>> core/link_port_pkg.sv
// Types shared by the link port modules.
// Assumes link_port_defines.svh supplies the numeric constants.
package link_port_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [3:0] func_t;
	typedef logic [2:0] lu_sel_t;
	typedef logic [3:0] lu_addr_t;
	typedef logic [31:0] data_t;
	typedef struct packed {
		func_t func;
		data_t data;
	} in_word_t;
	typedef enum logic [0:0] {IN_IDLE, IN_GRANT} in_state_t;
	typedef enum logic [0:0] {OUT_IDLE, OUT_LOAD} out_state_t;
	typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_DONE} rd_state_t;
endpackage : link_port_pkg

// >>> core/word_buf_if.sv
// Valid/ready carrier between the port logic and its inward buffer.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
`default_nettype none
interface word_buf_if;
	import link_port_pkg::*;
	logic push_valid;
	logic push_ready;
	in_word_t push_data;
	logic pop_valid;
	logic pop_ready;
	in_word_t pop_data;
	modport buffer (input push_valid, push_data, pop_ready,
		output push_ready, pop_valid, pop_data);
	modport owner (output push_valid, push_data, pop_ready,
		input push_ready, pop_valid, pop_data);
endinterface : word_buf_if
`default_nettype wire

// >>> core/word_buf2.sv
// Two-entry buffer for inward words, honest full and empty.
// Assumes an active-low reset, released synchronously by the port top.
`timescale 1ns/10ps
`default_nettype none
module word_buf2 (
	input wire logic clk,
	input wire logic rst_n,
	word_buf_if.buffer bus
);
	import link_port_pkg::*;

	in_word_t mem_q [2];
	in_word_t mem_d [2];
	logic wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
	logic [1:0] cnt_q, cnt_d;
	logic push, pop;

	// ============================================================
	// Flags and next state
	assign bus.push_ready = (cnt_q != 2'h2);
	assign bus.pop_valid = (cnt_q != 2'h0);
	assign bus.pop_data = mem_q[rd_ptr_q];
	assign push = bus.push_valid && bus.push_ready;
	assign pop = bus.pop_valid && bus.pop_ready;

	always_comb begin
		mem_d = mem_q;
		if (push) begin
			mem_d[wr_ptr_q] = bus.push_data;
		end
		wr_ptr_d = push ? ~wr_ptr_q : wr_ptr_q;
		rd_ptr_d = pop ? ~rd_ptr_q : rd_ptr_q;
		cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			mem_q <= mem_d;
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			cnt_q <= cnt_d;
		end
	end
endmodule : word_buf2
`default_nettype wire

// >>> core/link_port.sv
// Host register port and line unit interface of the link processor.
// Assumes one clock mclk; host strobes are synchronous to mclk.
`timescale 1ns/10ps
`default_nettype none
`include "link_port_defines.svh"
module link_port (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [2:0] host_addr,
	input wire logic [1:0] host_be,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [15:0] host_wdata,
	output logic [15:0] host_rdata,
	output logic host_rvalid,
	output logic in_valid,
	input wire logic in_ready,
	output link_port_pkg::func_t in_func,
	output link_port_pkg::data_t in_data,
	input wire logic out_valid,
	output logic out_ready,
	input wire link_port_pkg::func_t out_func,
	input wire link_port_pkg::data_t out_data,
	input wire logic lu_rd_req,
	input wire link_port_pkg::lu_sel_t lu_rd_sel,
	output logic lu_rd_busy,
	output logic lu_rd_done,
	output link_port_pkg::byte_t lu_rd_result,
	input wire logic lu_wr_req,
	input wire link_port_pkg::lu_sel_t lu_wr_sel,
	input wire link_port_pkg::byte_t lu_wr_byte,
	output link_port_pkg::lu_addr_t lu_in_addr,
	input wire link_port_pkg::byte_t lu_in_bus,
	output link_port_pkg::lu_addr_t lu_out_addr,
	output link_port_pkg::byte_t lu_out_bus,
	output logic lu_clk_sync,
	output logic lu_data_strobe
);
	import link_port_pkg::*;

	// Byte lane selected at a given register offset; reads only its arguments
	// so that continuous assignments see every change of its inputs
	function automatic logic lane_wr(input logic [2:0] a, input logic [1:0] be,
		input logic [2:0] off, input int lane);
		lane_wr = (a[2:1] == off[2:1]) && be[lane];
	endfunction : lane_wr

	// ============================================================
	// Reset release
	logic rst_s1_q, rst_s2_q;
	logic rst_n;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign rst_n = rst_s2_q;

	// ============================================================
	// Inward buffer
	// Words wait here so a stalled receiver loses nothing
	word_buf_if wb ();
	word_buf2 u_buf (
		.clk(mclk),
		.rst_n(rst_n),
		.bus(wb.buffer)
	);
	assign in_valid = wb.pop_valid;
	assign wb.pop_ready = in_ready;
	assign in_func = wb.pop_data.func;
	assign in_data = wb.pop_data.data;

	// ============================================================
	// Host visible registers and handshake state
	// Host strobes share mclk, so they need no synchroniser
	func_t func_in_q, func_in_d, func_out_q, func_out_d;
	logic host_request_in_q, host_request_in_d;
	logic device_ready_in_q, device_ready_in_d;
	logic device_ready_out_q, device_ready_out_d;
	byte_t data_port_q [4];
	byte_t data_port_d [4];
	in_state_t in_st_q, in_st_d;
	out_state_t out_st_q, out_st_d;
	logic port_load;
	data_t data_word;
	logic in_hs_we, out_hs_we;
	logic [3:0] dp_we;

	// ============================================================
	// Byte lane write enables
	assign in_hs_we = host_wr && lane_wr(host_addr, host_be, `OFF_IN_HS, 0);
	assign out_hs_we = host_wr && lane_wr(host_addr, host_be, `OFF_OUT_HS, 0);
	for (genvar g = 0; g < 4; g++) begin : g_dp_we
		assign dp_we[g] = host_wr
			&& lane_wr(host_addr, host_be, (g < 2) ? `OFF_DATA_LO : `OFF_DATA_HI, g % 2);
	end

	assign data_word = {data_port_q[3], data_port_q[2], data_port_q[1], data_port_q[0]};
	assign wb.push_data = '{func: func_in_q, data: data_word};
	assign wb.push_valid = (in_st_q == IN_GRANT) && !host_request_in_q;
	assign port_load = (out_st_q == OUT_IDLE) && (in_st_q == IN_IDLE) && !host_request_in_q
		&& !device_ready_out_q;
	assign out_ready = port_load && out_valid;

	always_comb begin
		func_in_d = func_in_q;
		host_request_in_d = host_request_in_q;
		device_ready_in_d = device_ready_in_q;
		device_ready_out_d = device_ready_out_q;
		func_out_d = func_out_q;
		data_port_d = data_port_q;
		in_st_d = in_st_q;
		out_st_d = out_st_q;
		if (in_hs_we) begin
			func_in_d = host_wdata[`FUNC_MSB:`FUNC_LSB];
			host_request_in_d = host_wdata[`REQ_IN_BIT];
		end
		if (out_hs_we && !host_wdata[`RDY_OUT_BIT]) begin
			device_ready_out_d = 1'b0;
		end
		for (int i = 0; i < 4; i++) begin
			if (dp_we[i]) begin
				data_port_d[i] = host_wdata[8*(i%2) +: 8];
			end
		end
		unique case (in_st_q)
			IN_IDLE: begin
				// Ready-in waits while the outward side owns the port
				if (host_request_in_q && !device_ready_out_q && out_st_q == OUT_IDLE) begin
					device_ready_in_d = 1'b1;
					in_st_d = IN_GRANT;
				end
			end
			IN_GRANT: begin
				// A full buffer stalls here with ready-in still high
				if (wb.push_valid && wb.push_ready) begin
					device_ready_in_d = 1'b0;
					in_st_d = IN_IDLE;
				end
			end
		endcase
		unique case (out_st_q)
			OUT_IDLE: begin
				if (out_ready) begin
					data_port_d = '{out_data[7:0], out_data[15:8], out_data[23:16],
						out_data[31:24]};
					func_out_d = out_func;
					out_st_d = OUT_LOAD;
				end
			end
			OUT_LOAD: begin
				// Set after the load; wins over a host clear in the same cycle
				device_ready_out_d = 1'b1;
				out_st_d = OUT_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			func_in_q <= `RST_FUNC;
			func_out_q <= `RST_FUNC;
			host_request_in_q <= 1'b0;
			device_ready_in_q <= 1'b0;
			device_ready_out_q <= 1'b0;
			data_port_q <= '{`RST_BYTE, `RST_BYTE, `RST_BYTE, `RST_BYTE};
			in_st_q <= IN_IDLE;
			out_st_q <= OUT_IDLE;
		end else begin
			func_in_q <= func_in_d;
			func_out_q <= func_out_d;
			host_request_in_q <= host_request_in_d;
			device_ready_in_q <= device_ready_in_d;
			device_ready_out_q <= device_ready_out_d;
			data_port_q <= data_port_d;
			in_st_q <= in_st_d;
			out_st_q <= out_st_d;
		end
	end

	// ============================================================
	// Host read path
	// Odd handshake bytes read as zero
	logic [15:0] rdata_d;
	logic rvalid_d;
	always_comb begin
		rdata_d = host_rdata;
		rvalid_d = host_rd;
		if (host_rd) begin
			unique case (host_addr[2:1])
				2'h0: rdata_d = {8'h00, device_ready_in_q, 1'b0, host_request_in_q, 1'b0,
					func_in_q};
				2'h1: rdata_d = {8'h00, device_ready_out_q, 3'h0, func_out_q};
				2'h2: rdata_d = {data_port_q[1], data_port_q[0]};
				2'h3: rdata_d = {data_port_q[3], data_port_q[2]};
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			host_rdata <= 16'h0000;
			host_rvalid <= 1'b0;
		end else begin
			host_rdata <= rdata_d;
			host_rvalid <= rvalid_d;
		end
	end

	// ============================================================
	// Line unit read channel
	// Input bus passes two flops; the read wait covers their latency
	byte_t lu_in_s1_q, lu_in_s2_q;
	rd_state_t rd_st_q, rd_st_d;
	logic [1:0] rd_cnt_q, rd_cnt_d;
	lu_addr_t lu_in_addr_d;
	byte_t rd_result_d;

	always_comb begin
		rd_st_d = rd_st_q;
		rd_cnt_d = rd_cnt_q;
		lu_in_addr_d = lu_in_addr;
		rd_result_d = lu_rd_result;
		unique case (rd_st_q)
			RD_IDLE: begin
				if (lu_rd_req) begin
					lu_in_addr_d = {1'b0, lu_rd_sel};
					rd_cnt_d = `LU_RD_WAIT;
					rd_st_d = RD_WAIT;
				end
			end
			RD_WAIT: begin
				rd_cnt_d = rd_cnt_q - 2'h1;
				if (rd_cnt_q == 2'h1) begin
					rd_result_d = lu_in_s2_q;
					rd_st_d = RD_DONE;
				end
			end
			RD_DONE: begin
				rd_st_d = RD_IDLE;
			end
			default: begin
				rd_st_d = RD_IDLE;
			end
		endcase
	end

	assign lu_rd_busy = (rd_st_q != RD_IDLE);
	assign lu_rd_done = (rd_st_q == RD_DONE);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			lu_in_s1_q <= 8'h00;
			lu_in_s2_q <= 8'h00;
			rd_st_q <= RD_IDLE;
			rd_cnt_q <= 2'h0;
			lu_in_addr <= 4'h0;
			lu_rd_result <= 8'h00;
		end else begin
			lu_in_s1_q <= lu_in_bus;
			lu_in_s2_q <= lu_in_s1_q;
			rd_st_q <= rd_st_d;
			rd_cnt_q <= rd_cnt_d;
			lu_in_addr <= lu_in_addr_d;
			lu_rd_result <= rd_result_d;
		end
	end

	// ============================================================
	// Line unit write channel and control signals
	// Write enable and strobe last one cycle, so each request writes once
	lu_addr_t lu_out_addr_d;
	byte_t lu_out_bus_d;
	logic strobe_d, sync_d;
	logic [3:0] div_q, div_d;

	always_comb begin
		lu_out_addr_d = {1'b0, lu_out_addr[2:0]};
		lu_out_bus_d = lu_out_bus;
		strobe_d = 1'b0;
		if (lu_wr_req) begin
			lu_out_addr_d = {1'b1, lu_wr_sel};
			lu_out_bus_d = lu_wr_byte;
			strobe_d = 1'b1;
		end
		// Sync pulses once per divider period
		div_d = (div_q == `CLK_SYNC_DIV) ? 4'h0 : div_q + 4'h1;
		sync_d = (div_q == `CLK_SYNC_DIV);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			lu_out_addr <= 4'h0;
			lu_out_bus <= 8'h00;
			lu_data_strobe <= 1'b0;
			lu_clk_sync <= 1'b0;
			div_q <= 4'h0;
		end else begin
			lu_out_addr <= lu_out_addr_d;
			lu_out_bus <= lu_out_bus_d;
			lu_data_strobe <= strobe_d;
			lu_clk_sync <= sync_d;
			div_q <= div_d;
		end
	end
endmodule : link_port
`default_nettype wire

// >>> dv/link_port_asserts.sv
// Checker for the line unit and word ports of the link port.
// Assumes it is bound to link_port and runs on mclk.
`timescale 1ns/10ps
`default_nettype none
module link_port_asserts (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic in_valid,
	input wire logic in_ready,
	input wire link_port_pkg::func_t in_func,
	input wire link_port_pkg::data_t in_data,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic lu_rd_req,
	input wire link_port_pkg::lu_sel_t lu_rd_sel,
	input wire logic lu_rd_busy,
	input wire logic lu_rd_done,
	input wire logic lu_wr_req,
	input wire link_port_pkg::lu_sel_t lu_wr_sel,
	input wire link_port_pkg::byte_t lu_wr_byte,
	input wire link_port_pkg::lu_addr_t lu_in_addr,
	input wire link_port_pkg::lu_addr_t lu_out_addr,
	input wire link_port_pkg::byte_t lu_out_bus,
	input wire logic lu_clk_sync,
	input wire logic lu_data_strobe
);
	import link_port_pkg::*;
	// ============================================================
	// Properties
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	rd_addr_a: assert property (lu_rd_req && !lu_rd_busy |=>
		lu_rd_busy && lu_in_addr == {1'b0, $past(lu_rd_sel)}) else $error("bad read address");
	rd_top_low_a: assert property (!lu_in_addr[3]) else $error("read address top set");
	wr_addr_a: assert property (lu_wr_req |=> lu_out_addr == {1'b1, $past(lu_wr_sel)} &&
		lu_out_bus == $past(lu_wr_byte) && lu_data_strobe) else $error("bad write cycle");
	wr_enable_a: assert property (lu_out_addr[3] || lu_data_strobe |->
		$past(lu_wr_req)) else $error("write enable without request");
	rd_done_a: assert property (lu_rd_req && !lu_rd_busy |->
		##[4:5] lu_rd_done) else $error("read not done");
	clk_sync_a: assert property (lu_clk_sync |=>
		!lu_clk_sync [*8] ##1 !lu_clk_sync [*7] ##1 lu_clk_sync) else $error("sync period wrong");
	out_excl_a: assert property (out_valid && out_ready |=>
		!out_ready [*2]) else $error("outward taken twice");
	in_hold_a: assert property (in_valid && !in_ready |=>
		in_valid && $stable({in_func, in_data})) else $error("inward word dropped");
	cover property (lu_rd_done);
	cover property (in_valid && in_ready);
	cover property (out_valid && out_ready);
endmodule : link_port_asserts
bind link_port link_port_asserts chk (.mclk, .nrst, .in_valid, .in_ready, .in_func, .in_data,
	.out_valid, .out_ready, .lu_rd_req, .lu_rd_sel, .lu_rd_busy, .lu_rd_done, .lu_wr_req,
	.lu_wr_sel, .lu_wr_byte, .lu_in_addr, .lu_out_addr, .lu_out_bus, .lu_clk_sync,
	.lu_data_strobe);
`default_nettype wire

// >>> dv/line_unit_model.sv
// Line unit model: eight byte registers behind the link port.
// Assumes writes are marked by address top bit and strobe.
`timescale 1ns/10ps
`default_nettype none
module line_unit_model (
	input wire logic mclk,
	input wire link_port_pkg::lu_addr_t lu_in_addr,
	output link_port_pkg::byte_t lu_in_bus,
	input wire link_port_pkg::lu_addr_t lu_out_addr,
	input wire link_port_pkg::byte_t lu_out_bus,
	input wire logic lu_data_strobe
);
	import link_port_pkg::*;
	// ============================================================
	// Registers
	byte_t regs_q [8] = '{default: 8'h00};
	always @(posedge mclk) begin
		if (lu_out_addr[3] && lu_data_strobe)
			regs_q[lu_out_addr[2:0]] <= lu_out_bus;
	end
	// Not a read address: drive the inverse so stale data never matches
	assign lu_in_bus = lu_in_addr[3] ? ~regs_q[lu_in_addr[2:0]] : regs_q[lu_in_addr[2:0]];
endmodule : line_unit_model
`default_nettype wire

// >>> dv/test_link_processor_host_port.sv
// Self-checking bench for the link port.
// Assumes link_port, its package and the line unit model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_link_processor_host_port;
	import link_port_pkg::*;
	logic mclk = 1'b0, nrst = 1'b0, host_wr = 1'b0, host_rd = 1'b0, host_rvalid;
	logic [2:0] host_addr = 3'h0;
	logic [1:0] host_be = 2'h0;
	logic [15:0] host_wdata = 16'h0000, host_rdata;
	logic in_valid, in_ready = 1'b0, out_valid = 1'b0, out_ready, lu_rd_busy, lu_rd_done;
	logic lu_rd_req = 1'b0, lu_wr_req = 1'b0, lu_clk_sync, lu_data_strobe;
	func_t in_func, out_func = 4'h0, f;
	data_t in_data, out_data = 32'h0, d;
	lu_sel_t lu_rd_sel = 3'h0, lu_wr_sel = 3'h0;
	byte_t lu_rd_result, lu_wr_byte = 8'h00, lu_in_bus, lu_out_bus;
	byte_t shadow [8] = '{default: 8'h00};
	lu_addr_t lu_in_addr, lu_out_addr;
	int err_count = 0, checks = 0, seed = 32'hd9dd6b17;
	logic [35:0] qh[$], qi[$], qr[$];
	logic [35:0] stray_v = 36'hF_FFFF_FFFF;
	always #5 mclk = ~mclk;
	link_port uut (.mclk, .nrst, .host_addr, .host_be, .host_wr, .host_rd, .host_wdata,
		.host_rdata, .host_rvalid, .in_valid, .in_ready, .in_func, .in_data, .out_valid,
		.out_ready, .out_func, .out_data, .lu_rd_req, .lu_rd_sel, .lu_rd_busy, .lu_rd_done,
		.lu_rd_result, .lu_wr_req, .lu_wr_sel, .lu_wr_byte, .lu_in_addr, .lu_in_bus,
		.lu_out_addr, .lu_out_bus, .lu_clk_sync, .lu_data_strobe);
	line_unit_model model (.mclk, .lu_in_addr, .lu_in_bus, .lu_out_addr, .lu_out_bus,
		.lu_data_strobe);
	// ============================================================
	// Tasks
	task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t mismatch got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	task automatic host(input logic rd, input logic [2:0] a, input logic [1:0] be,
		input logic [15:0] v);
		@(posedge mclk);
		host_addr <= a;
		host_be <= be;
		host_wdata <= v;
		host_wr <= !rd;
		host_rd <= rd;
		if (rd)
			qh.push_back({20'h0, v});
		@(posedge mclk);
		host_wr <= 1'b0;
		host_rd <= 1'b0;
	endtask : host
	// ============================================================
	// Monitor
	always @(posedge mclk) begin
		if (nrst) begin
			if (host_rvalid !== 1'b0)
				chk(host_rdata, (qh.size() > 0) ? qh.pop_front() : stray_v);
			if ((in_valid && in_ready) !== 1'b0)
				chk({in_func, in_data}, (qi.size() > 0) ? qi.pop_front() : stray_v);
			if (lu_rd_done !== 1'b0)
				chk(lu_rd_result, (qr.size() > 0) ? qr.pop_front() : stray_v);
		end
	end
	initial begin
		#200000;
		err_count++;
		give_verdict();
	end
	// ============================================================
	// Sequence
	initial begin
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		repeat (3) @(posedge mclk);
		host(1, 3'h0, 2'b11, 16'h0000);
		for (int k = 0; k < 2; k++) begin
			f = 4'($random(seed));
			d = $random(seed);
			host(0, 3'h0, 2'b01, {8'h00, 8'h20 | f});
			repeat (3) @(posedge mclk);
			host(1, 3'h0, 2'b11, {8'h00, 8'hA0 | f});
			host(0, 3'h4, 2'b01, {8'h5A, d[7:0]});
			host(0, 3'h5, 2'b10, {d[15:8], 8'hA5});
			host(0, 3'h6, 2'b11, d[31:16]);
			host(0, 3'h0, 2'b01, {12'h000, f});
			qi.push_back({f, d});
			repeat (4) @(posedge mclk);
			host(1, 3'h0, 2'b11, {12'h000, f});
		end
		host(0, 3'h1, 2'b10, 16'hFF00);
		host(1, 3'h0, 2'b11, {12'h000, f});
		in_ready <= 1'b1;
		for (int i = 0; i < 20 && qi.size() > 0; i++) @(posedge mclk);
		chk(qi.size(), 36'h0);
		$display("inward test done");
		f = 4'($random(seed));
		d = $random(seed);
		out_valid <= 1'b1;
		out_func <= f;
		out_data <= d;
		for (int i = 0; i < 20 && !(out_valid && out_ready); i++) @(posedge mclk);
		chk(out_valid && out_ready, 1'b1);
		out_valid <= 1'b0;
		repeat (3) @(posedge mclk);
		host(1, 3'h2, 2'b11, {8'h00, 8'h80 | f});
		host(1, 3'h4, 2'b11, d[15:0]);
		host(1, 3'h6, 2'b11, d[31:16]);
		host(0, 3'h2, 2'b01, 16'h0080);
		host(1, 3'h2, 2'b11, {8'h00, 8'h80 | f});
		host(0, 3'h0, 2'b01, {8'h00, 8'h20 | f});
		repeat (4) @(posedge mclk);
		host(1, 3'h0, 2'b11, {8'h00, 8'h20 | f});
		host(0, 3'h2, 2'b01, 16'h0000);
		repeat (3) @(posedge mclk);
		host(1, 3'h0, 2'b11, {8'h00, 8'hA0 | f});
		host(0, 3'h0, 2'b01, {12'h000, f});
		qi.push_back({f, d});
		host(1, 3'h2, 2'b11, {12'h000, f});
		$display("outward test done");
		for (int i = 0; i < 9; i++) begin
			d[7:0] = 8'($random(seed));
			@(posedge mclk);
			lu_wr_req <= (i < 8);
			lu_wr_sel <= 3'(i);
			lu_wr_byte <= d[7:0];
			lu_rd_req <= 1'b1;
			lu_rd_sel <= 3'(i + 7);
			qr.push_back({28'h0, shadow[(i + 7) % 8]});
			if (i < 8)
				shadow[i] = d[7:0];
			@(posedge mclk);
			lu_wr_req <= 1'b0;
			lu_rd_req <= 1'b0;
			repeat (7) @(posedge mclk);
		end
		$display("line unit test done");
		for (int i = 0; i < 40 && qh.size() + qi.size() + qr.size() > 0; i++) @(posedge mclk);
		chk(qh.size() + qi.size() + qr.size(), 36'h0);
		give_verdict();
	end
endmodule : test_link_processor_host_port
`default_nettype wire
